// >>> hdl/efim_irq_mask.sv
`timescale 1ns/1ns
module efim_irq_mask (
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Avalon-MM slave, byte address
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Condition levels, change of state is the event; aux pattern status counts its rise only
  input wire logic frame_sync_loss,
  input wire logic multiframe_sync,
  input wire logic crc_multiframe_sync,
  input wire logic alarm_signal,
  input wire logic signal_loss,
  input wire logic remote_multiframe_alarm,
  input wire logic aux_pattern_status,
  input wire logic [3:0] spare_bits,
  // Event pulses, one cycle each
  input wire logic double_frame_error,
  input wire logic frame_slip,
  input wire logic frame_word_error,
  input wire logic local_crc_error,
  input wire logic far_end_error_bit,
  input wire logic slot16_alarm,
  input wire logic line_violation,
  input wire logic pattern_error,
  input wire logic remote_alarm,
  input wire logic frame_error_count_wrap,
  input wire logic crc_count_wrap,
  input wire logic far_end_count_wrap,
  input wire logic violation_count_wrap,
  input wire logic pattern_count_wrap,
  input wire logic pattern_multiframe_wrap,
  input wire logic spare_nibble_change,
  // Interrupt request pin, active low
  output logic irq_n_o,
  output logic irq_n_oe
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  localparam int NE = efim_pkg::NUM_EVENTS;
  logic [7:0] mask0_r; // Sync and alarm enables
  logic [7:0] mask1_r; // Error event enables
  logic [7:0] mask2_r; // Counter overflow and spare bit enables
  logic [7:0] ctrl_r; // Suspend, acknowledge, spare select
  logic ack_d_r; // Last seen acknowledge level
  logic primed_r; // Level history valid
  logic [5:0] lvl_d_r; // Previous condition levels
  logic aux_d_r; // Previous aux pattern status
  logic [3:0] sa_d_r; // Previous spare bits
  logic [NE-1:0] pend_r; // Pending events
  logic [NE-1:0] evt; // Raw events this cycle
  logic [NE-1:0] mask_all; // All enables together
  logic [5:0] lvl; // Condition levels now
  logic ack_tog; // Acknowledge edge seen
  logic suspend; // Interrupts suspended
  logic [7:0] idx; // Register index
  logic take_wr; // Write takes effect
  logic [31:0] rd_nxt; // Read data to load

  assign lvl = {frame_sync_loss, multiframe_sync, crc_multiframe_sync,
                alarm_signal, signal_loss, remote_multiframe_alarm};
  assign suspend = ctrl_r[efim_pkg::CTRL_SUSPEND];
  assign ack_tog = ctrl_r[efim_pkg::CTRL_ACK] != ack_d_r;
  assign mask_all = {mask2_r, mask1_r, mask0_r};
  assign idx = avs_address[efim_pkg::ADDR_SHIFT +: 8];
  assign take_wr = avs_write && !avs_waitrequest;

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  // Waitrequest drops one cycle after a request, for one cycle
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    end
  end

  // Read mux, unmapped and reserved bits read zero
  always_comb begin
    rd_nxt = efim_pkg::UNMAPPED_DATA;
    unique case (idx)
      efim_pkg::IDX_CTRL: rd_nxt[7:0] = ctrl_r;
      efim_pkg::IDX_MASK0: rd_nxt[7:0] = mask0_r;
      efim_pkg::IDX_MASK1: rd_nxt[7:0] = mask1_r;
      efim_pkg::IDX_MASK2: rd_nxt[7:0] = mask2_r;
      efim_pkg::IDX_PEND0: rd_nxt[7:0] = pend_r[7:0];
      efim_pkg::IDX_PEND1: rd_nxt[7:0] = pend_r[15:8];
      efim_pkg::IDX_PEND2: rd_nxt[7:0] = pend_r[23:16];
      efim_pkg::IDX_STAT: rd_nxt[0] = !irq_n_o;
      default: rd_nxt = efim_pkg::UNMAPPED_DATA;
    endcase
  end

  // Read data loaded as waitrequest drops
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      avs_readdata <= efim_pkg::UNMAPPED_DATA;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= rd_nxt;
    end
  end

  // Mask words, writable registers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      mask0_r <= efim_pkg::MASK_RST;
      mask1_r <= efim_pkg::MASK_RST;
      mask2_r <= efim_pkg::MASK_RST;
    end else if (take_wr) begin
      // Byte 0 carries each word
      if (idx == efim_pkg::IDX_MASK0) begin
        mask0_r <= avs_writedata[7:0];
      end
      if (idx == efim_pkg::IDX_MASK1) begin
        mask1_r <= avs_writedata[7:0];
      end
      if (idx == efim_pkg::IDX_MASK2) begin
        mask2_r <= avs_writedata[7:0] & efim_pkg::MASK2_USED;
      end
    end
  end

  // Control word
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrl_r <= efim_pkg::CTRL_RST;
    end else if (take_wr && idx == efim_pkg::IDX_CTRL) begin
      ctrl_r <= avs_writedata[7:0];
    end
  end

  // ----------------------------------------
  // Event detection
  // ----------------------------------------
  // History of levels; first cycle after reset only primes it
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      primed_r <= 1'b0;
      lvl_d_r <= 6'h00;
      aux_d_r <= 1'b0;
      sa_d_r <= 4'h0;
      ack_d_r <= 1'b0;
    end else begin
      primed_r <= 1'b1;
      lvl_d_r <= lvl;
      aux_d_r <= aux_pattern_status;
      sa_d_r <= spare_bits;
      ack_d_r <= ctrl_r[efim_pkg::CTRL_ACK];
    end
  end

  // Event vector, bit n of word w sits at 8*w+n
  always_comb begin
    evt = '0;
    // Change of any condition except aux pattern status, either direction
    evt[7] = primed_r && (lvl[5] != lvl_d_r[5]);
    evt[6] = primed_r && (lvl[4] != lvl_d_r[4]);
    evt[5] = primed_r && (lvl[3] != lvl_d_r[3]);
    evt[4] = primed_r && (lvl[2] != lvl_d_r[2]);
    evt[3] = primed_r && (lvl[1] != lvl_d_r[1]);
    evt[2] = double_frame_error;
    evt[1] = primed_r && (lvl[0] != lvl_d_r[0]);
    evt[0] = frame_slip;
    evt[15] = frame_word_error;
    evt[14] = local_crc_error;
    evt[13] = far_end_error_bit;
    evt[12] = slot16_alarm;
    evt[11] = line_violation;
    evt[10] = pattern_error;
    evt[9] = primed_r && aux_pattern_status && !aux_d_r;
    evt[8] = remote_alarm;
    evt[23] = frame_error_count_wrap;
    evt[22] = crc_count_wrap;
    evt[20] = far_end_count_wrap;
    evt[19] = violation_count_wrap;
    evt[18] = pattern_count_wrap;
    evt[17] = pattern_multiframe_wrap;
    // Spare bits or nibbles by the select bit
    if (ctrl_r[efim_pkg::CTRL_SA_SEL]) begin
      evt[16] = primed_r && (spare_bits != sa_d_r);
    end else begin
      evt[16] = spare_nibble_change;
    end
  end

  // ----------------------------------------
  // Pending latches
  // ----------------------------------------
  // One sticky bit per event; a new event beats the clear
  for (genvar i = 0; i < NE; i++) begin : g_pend
    always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
        pend_r[i] <= 1'b0;
      end else if (evt[i] && mask_all[i] && !suspend) begin
        pend_r[i] <= 1'b1;
      end else if (ack_tog) begin
        pend_r[i] <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Request pin
  // ----------------------------------------
  // Low while anything pends, released while suspended
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      irq_n_o <= 1'b1;
      irq_n_oe <= 1'b0;
    end else begin
      irq_n_o <= !(|pend_r);
      irq_n_oe <= !suspend;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  masked_block_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (evt[0] && !mask_all[0] && !pend_r[0] && !ack_tog) |=> !pend_r[0])
    else $error("masked slip event latched");
  sync_change_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (primed_r && $changed(frame_sync_loss) && mask0_r[7] && !suspend) |=> pend_r[7])
    else $error("frame sync change not latched");
  slip_irq_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (frame_slip && mask0_r[0] && !suspend) |=> ##1 !irq_n_o)
    else $error("slip did not raise request");
  aux_rise_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (primed_r && $rose(aux_pattern_status) && mask1_r[1] && !suspend) |=> pend_r[9])
    else $error("aux pattern rise not latched");
  unused_bit_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !mask2_r[5] && !pend_r[21])
    else $error("unused overflow bit active");
  spare_sel_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!ctrl_r[efim_pkg::CTRL_SA_SEL] && $changed(spare_bits) && !spare_nibble_change
      && !pend_r[16] && !ack_tog) |=> !pend_r[16])
    else $error("spare bit change seen in nibble mode");
  suspend_float_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    suspend |=> !irq_n_oe)
    else $error("request driven while suspended");
  ack_clear_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (ack_tog && !(|(evt & mask_all)) || ack_tog && suspend) |=> ##1 irq_n_o)
    else $error("acknowledge did not release request");
  hold_low_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!irq_n_o && !ack_tog && !$past(ack_tog)) |=> !irq_n_o)
    else $error("request dropped without acknowledge");
  // Every enabled event latches its pending bit at the next edge unless suspended
  multiframe_chg_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (primed_r && $changed(multiframe_sync) && mask0_r[6] && !suspend) |=> pend_r[6])
    else $error("multiframe sync change not latched");
  crc_sync_chg_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (primed_r && $changed(crc_multiframe_sync) && mask0_r[5] && !suspend) |=> pend_r[5])
    else $error("crc multiframe sync change not latched");
  alarm_chg_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (primed_r && $changed(alarm_signal) && mask0_r[4] && !suspend) |=> pend_r[4])
    else $error("alarm signal change not latched");
  signal_loss_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (primed_r && $changed(signal_loss) && mask0_r[3] && !suspend) |=> pend_r[3])
    else $error("signal loss change not latched");
  double_err_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (double_frame_error && mask0_r[2] && !suspend) |=> pend_r[2])
    else $error("double frame error not latched");
  remote_mf_chg_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (primed_r && $changed(remote_multiframe_alarm) && mask0_r[1] && !suspend) |=> pend_r[1])
    else $error("remote multiframe alarm change not latched");
  frame_err_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (frame_word_error && mask1_r[7] && !suspend) |=> pend_r[15])
    else $error("frame word error not latched");
  local_crc_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (local_crc_error && mask1_r[6] && !suspend) |=> pend_r[14])
    else $error("local crc error not latched");
  far_end_err_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (far_end_error_bit && mask1_r[5] && !suspend) |=> pend_r[13])
    else $error("far end error not latched");
  slot16_alarm_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (slot16_alarm && mask1_r[4] && !suspend) |=> pend_r[12])
    else $error("slot 16 alarm not latched");
  violation_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (line_violation && mask1_r[3] && !suspend) |=> pend_r[11])
    else $error("line violation not latched");
  pattern_err_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (pattern_error && mask1_r[2] && !suspend) |=> pend_r[10])
    else $error("pattern error not latched");
  remote_alarm_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (remote_alarm && mask1_r[0] && !suspend) |=> pend_r[8])
    else $error("remote alarm not latched");
  frame_wrap_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (frame_error_count_wrap && mask2_r[7] && !suspend) |=> pend_r[23])
    else $error("frame error counter wrap not latched");
  crc_wrap_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (crc_count_wrap && mask2_r[6] && !suspend) |=> pend_r[22])
    else $error("crc counter wrap not latched");
  far_end_wrap_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (far_end_count_wrap && mask2_r[4] && !suspend) |=> pend_r[20])
    else $error("far end counter wrap not latched");
  violation_wrap_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (violation_count_wrap && mask2_r[3] && !suspend) |=> pend_r[19])
    else $error("violation counter wrap not latched");
  pattern_wrap_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (pattern_count_wrap && mask2_r[2] && !suspend) |=> pend_r[18])
    else $error("pattern counter wrap not latched");
  multiframe_wrap_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (pattern_multiframe_wrap && mask2_r[1] && !suspend) |=> pend_r[17])
    else $error("pattern multiframe wrap not latched");
  spare_bit_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (primed_r && ctrl_r[efim_pkg::CTRL_SA_SEL] && $changed(spare_bits) && mask2_r[0]
      && !suspend) |=> pend_r[16])
    else $error("spare bit change not latched in bit mode");
  suspend_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (suspend && !ack_tog) |=> $stable(pend_r))
    else $error("pending changed while suspended");

endmodule

// >>> pkg/efim_pkg.sv
// ----------------------------------------
// Register map and field layout
// ----------------------------------------
package efim_pkg;
  // Register indices; byte address is index times four
  localparam logic [7:0] IDX_CTRL = 8'h1a;
  localparam logic [7:0] IDX_MASK0 = 8'h1b;
  localparam logic [7:0] IDX_MASK1 = 8'h1c;
  localparam logic [7:0] IDX_MASK2 = 8'h1d;
  localparam logic [7:0] IDX_PEND0 = 8'h20;
  localparam logic [7:0] IDX_PEND1 = 8'h21;
  localparam logic [7:0] IDX_PEND2 = 8'h22;
  localparam logic [7:0] IDX_STAT = 8'h23;
  // Byte address shift
  localparam int ADDR_SHIFT = 2;
  // Control register fields
  localparam int CTRL_SUSPEND = 6;
  localparam int CTRL_ACK = 5;
  localparam int CTRL_SA_SEL = 4;
  // Masks that hold an unused bit
  localparam logic [7:0] MASK2_USED = 8'hdf;
  // Reset values
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  // Answer for unmapped reads
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
  // Number of gated events
  localparam int NUM_EVENTS = 24;
endpackage

// >>> verification/efim_host_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// Host side of the interrupt request pin
// ----------------------------------------
module efim_host_model (
  input wire logic clk_sys,
  input wire logic irq_n_o,
  input wire logic irq_n_oe,
  output logic irq_line,
  output int irq_count
);
  // Previous pin level
  logic line_prev_r;
  // Board pull-up holds the line high while the device floats it
  assign irq_line = irq_n_oe ? irq_n_o : 1'b1;
  // Host counts one request per falling edge of the line
  always_ff @(posedge clk_sys) begin
    line_prev_r <= irq_line;
    if (line_prev_r === 1'b1 && irq_line === 1'b0) begin
      irq_count <= irq_count + 1;
    end
  end
endmodule

// >>> verification/efim_irq_mask_bench.sv
`timescale 1ns/1ns
// ----------------------------------------
// Bench for the interrupt mask block
// ----------------------------------------
module efim_irq_mask_bench;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [9:0] avs_address = 10'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  // Event vector, index is mask word times eight plus bit
  logic [23:0] ev = 24'h000000;
  logic [3:0] spare_bits = 4'h0;
  logic irq_n_o;
  logic irq_n_oe;
  logic irq_line;
  int irq_count;
  int errors = 0;
  int checks = 0;
  int nirq = 0;
  logic [7:0] ctl = 8'h00;
  logic [7:0] q;
  // Clock, 10 ns period
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  efim_irq_mask i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .frame_sync_loss(ev[7]), .multiframe_sync(ev[6]), .crc_multiframe_sync(ev[5]),
    .alarm_signal(ev[4]), .signal_loss(ev[3]), .double_frame_error(ev[2]),
    .remote_multiframe_alarm(ev[1]), .frame_slip(ev[0]), .frame_word_error(ev[15]),
    .local_crc_error(ev[14]), .far_end_error_bit(ev[13]), .slot16_alarm(ev[12]),
    .line_violation(ev[11]), .pattern_error(ev[10]), .aux_pattern_status(ev[9]),
    .remote_alarm(ev[8]), .frame_error_count_wrap(ev[23]), .crc_count_wrap(ev[22]),
    .far_end_count_wrap(ev[20]), .violation_count_wrap(ev[19]),
    .pattern_count_wrap(ev[18]), .pattern_multiframe_wrap(ev[17]),
    .spare_nibble_change(ev[16]), .spare_bits(spare_bits),
    .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe));
  efim_host_model i_host (.clk_sys(clk_sys), .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe),
    .irq_line(irq_line), .irq_count(irq_count));
  // ----------------------------------------
  // Report and close
  // ----------------------------------------
  task automatic results();
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Byte compare
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One Avalon access, held until waitrequest is sampled low
  task automatic acc(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    int n;
    avs_address <= {idx, 2'b00};
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
    if (n >= 50) begin
      errors++;
      results();
    end
  endtask
  // Read a register and compare
  task automatic rchk(input string what, input logic [7:0] idx, input logic [7:0] exp);
    acc(1'b0, idx, 8'h00);
    chk(what, exp, q);
  endtask
  // Toggle the acknowledge bit and let the clear reach the pin
  task automatic ack();
    ctl = ctl ^ 8'h20;
    acc(1'b1, efim_pkg::IDX_CTRL, ctl);
    repeat (3) @(posedge clk_sys);
    chk("irq after ack", 8'h01, {7'h00, irq_line});
  endtask
  // One-cycle event, then time for the request to settle
  task automatic fire(input int i);
    ev[i] <= 1'b1;
    @(posedge clk_sys);
    ev[i] <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    results();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [7:0] mi;
    logic [7:0] b;
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rchk("mask0 reset", efim_pkg::IDX_MASK0, 8'h00);
    rchk("mask2 reset", efim_pkg::IDX_MASK2, 8'h00);
    acc(1'b1, efim_pkg::IDX_MASK2, 8'hff);
    rchk("mask2 unused bit", efim_pkg::IDX_MASK2, 8'hdf);
    acc(1'b1, efim_pkg::IDX_MASK2, 8'h00);
    rchk("unmapped", 8'h30, 8'h00);
    // Each event alone: enabled raises, masked is dropped
    for (int i = 0; i < 24; i++) begin
      if (i != 21) begin
        mi = efim_pkg::IDX_MASK0 + 8'(i / 8);
        b = 8'h01 << (i % 8);
        acc(1'b1, mi, b);
        fire(i);
        nirq++;
        rchk("pending", efim_pkg::IDX_PEND0 + 8'(i / 8), b);
        chk("irq", 8'h00, {7'h00, irq_line});
        rchk("status", efim_pkg::IDX_STAT, 8'h01);
        acc(1'b1, mi, ~b);
        ack();
        fire(i);
        rchk("masked", efim_pkg::IDX_PEND0 + 8'(i / 8), 8'h00);
        chk("masked irq", 8'h01, {7'h00, irq_line});
        acc(1'b1, mi, 8'h00);
      end
    end
    // Spare bits: ignored in nibble mode, seen with bit selection
    acc(1'b1, efim_pkg::IDX_MASK2, 8'h01);
    spare_bits <= 4'h3;
    repeat (4) @(posedge clk_sys);
    rchk("spare nibble mode", efim_pkg::IDX_PEND2, 8'h00);
    ctl = ctl | 8'h10;
    acc(1'b1, efim_pkg::IDX_CTRL, ctl);
    spare_bits <= 4'h8;
    repeat (4) @(posedge clk_sys);
    nirq++;
    rchk("spare bit", efim_pkg::IDX_PEND2, 8'h01);
    ack();
    // Suspend floats the pin and drops events
    ctl = ctl | 8'h40;
    acc(1'b1, efim_pkg::IDX_CTRL, ctl);
    acc(1'b1, efim_pkg::IDX_MASK0, 8'h01);
    fire(0);
    chk("oe suspend", 8'h00, {7'h00, irq_n_oe});
    rchk("suspend drop", efim_pkg::IDX_PEND0, 8'h00);
    chk("requests", nirq[7:0], irq_count[7:0]);
    results();
  end
endmodule
